//--- hdl/vcc_pkg.sv
// Constants, types and register map of the voltage comparator control block.
package vcc_pkg;

    localparam int ADDR_W = 12;

    localparam logic [11:0] OFF_START = 12'h000;
    localparam logic [11:0] OFF_STOP = 12'h004;
    localparam logic [11:0] OFF_SAMPLE = 12'h008;
    localparam logic [11:0] OFF_READY = 12'h100;
    localparam logic [11:0] OFF_DOWN = 12'h104;
    localparam logic [11:0] OFF_UP = 12'h108;
    localparam logic [11:0] OFF_CROSS = 12'h10c;
    localparam logic [11:0] OFF_LINKS = 12'h200;
    localparam logic [11:0] OFF_IRQ_EN = 12'h300;
    localparam logic [11:0] OFF_IRQ_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFF_OUTCOME = 12'h400;
    localparam logic [11:0] OFF_ENABLE = 12'h500;
    localparam logic [11:0] OFF_PSEL = 12'h504;
    localparam logic [11:0] OFF_REFERENCE_SOURCE_SELECT = 12'h508;
    localparam logic [11:0] OFF_EXTREF = 12'h50c;
    localparam logic [11:0] OFF_LADDER = 12'h530;
    localparam logic [11:0] OFF_MODE = 12'h534;
    localparam logic [11:0] OFF_DEADBAND = 12'h538;

    // Flag index order is also the bit order of the interrupt enables.
    localparam int NUM_FLAGS = 4;
    localparam int FLG_READY = 0;
    localparam int FLG_DOWN = 1;
    localparam int FLG_UP = 2;
    localparam int FLG_CROSS = 3;
    localparam logic [11:0] FLAG_OFFS [0:3] = '{OFF_READY, OFF_DOWN, OFF_UP, OFF_CROSS};

    // Event to task links.
    localparam int LNK_READY_SAMPLE = 0;
    localparam int LNK_READY_STOP = 1;
    localparam int LNK_DOWN_STOP = 2;
    localparam int LNK_UP_STOP = 3;
    localparam int LNK_CROSS_STOP = 4;

    // Writable bits of each configuration register.
    localparam logic [31:0] MASK_LINKS = 32'h0000001f;
    localparam logic [31:0] MASK_IRQ = 32'h0000000f;
    localparam logic [31:0] MASK_ENABLE = 32'h00000003;
    localparam logic [31:0] MASK_SEL3 = 32'h00000007;
    localparam logic [31:0] MASK_LADDER = 32'h00003f3f;
    localparam logic [31:0] MASK_MODE = 32'h00000103;
    localparam logic [31:0] MASK_DEADBAND = 32'h00000001;
    localparam logic [31:0] REG_RESET = 32'h00000000;

    localparam int LVL_W = 6;
    localparam int LADDER_LOW_LSB = 0;
    localparam int LADDER_UP_LSB = 8;
    localparam int MODE_SPEED_LSB = 0;
    localparam int MODE_DIFF_BIT = 8;
    localparam int DEADBAND_BIT = 0;

    localparam logic [1:0] SPEED_LOW = 2'h0;
    localparam logic [1:0] SPEED_NORMAL = 2'h1;
    localparam logic [1:0] SPEED_HIGH = 2'h2;

    localparam logic [2:0] PSEL_HALF_SUPPLY = 3'h7;
    localparam logic [2:0] REF_INT_1V2 = 3'h0;
    localparam logic [2:0] REF_INT_1V8 = 3'h1;
    localparam logic [2:0] REF_INT_2V4 = 3'h2;
    localparam logic [2:0] REF_SUPPLY = 3'h4;
    localparam logic [2:0] REF_PIN = 3'h5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_NS = 20;
    localparam int STARTUP_NS = 1000;
    localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WARM_W = 8;
    localparam logic [WARM_W-1:0] WARM_LAST = WARM_W'(STARTUP_CYC - 1);

    typedef enum logic [1:0] {
        VCC_IDLE = 2'b00,
        VCC_WARMUP = 2'b01,
        VCC_RUN = 2'b11
    } vcc_state_e;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } vcc_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } vcc_axil_rsp_s;

endpackage : vcc_pkg

//--- hdl/vcc_axil_slave.sv
// AXI4-Lite slave front end that turns bus channels into one write strobe and a read lookup.
`timescale 1ns/1ps
module vcc_axil_slave
    import vcc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Bus
    input wire vcc_axil_req_s req,
    output vcc_axil_rsp_s rsp,
    // Register file side
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic aw_held;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    // Address and data are held separately so they may arrive in either order.
    assign wr_en = aw_held && w_held && !bvalid;
    assign rd_addr = req.araddr;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            wr_addr <= '0;
        end else if (req.awvalid && !aw_held) begin
            aw_held <= 1'b1;
            wr_addr <= req.awaddr;
        end else if (wr_en) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (req.wvalid && !w_held) begin
            w_held <= 1'b1;
            wr_data <= req.wdata;
            wr_strb <= req.wstrb;
        end else if (wr_en) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (req.bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (req.arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (req.rready) begin
            rvalid <= 1'b0;
        end
    end

    always_comb begin
        rsp = '0;
        rsp.awready = !aw_held;
        rsp.wready = !w_held;
        rsp.bvalid = bvalid;
        rsp.bresp = bresp;
        rsp.arready = !rvalid;
        rsp.rvalid = rvalid;
        rsp.rdata = rdata;
        rsp.rresp = rresp;
    end

endmodule : vcc_axil_slave

//--- hdl/vcc_top.sv
// Digital control of the voltage comparator: registers, start-up sequencing, events and ladder steering.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module vcc_top
    import vcc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register bus
    input wire vcc_axil_req_s axil_req,
    output vcc_axil_rsp_s axil_rsp,
    // Analog comparator core
    input wire logic core_above_async,
    output logic core_power,
    output logic [1:0] core_speed,
    output logic core_diff_mode,
    output logic core_diff_diff_deadband_enable,
    output logic [2:0] pos_select,
    output logic [2:0] ref_source,
    output logic [2:0] ext_ref_pin,
    output logic [LVL_W-1:0] ladder_level,
    output logic pins_claimed,
    // Interrupt request
    output logic irq
);

    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    logic [31:0] enable_r;
    logic [31:0] psel_r;
    logic [31:0] reference_source_select_r;
    logic [31:0] extref_r;
    logic [31:0] ladder_r;
    logic [31:0] mode_r;
    logic [31:0] deadband_r;
    logic [31:0] links_r;
    logic [31:0] irq_en_r;
    logic [NUM_FLAGS-1:0] flag;
    logic [NUM_FLAGS-1:0] ev;
    logic outcome;

    vcc_state_e state;
    vcc_state_e next_state;
    logic [WARM_W-1:0] warm_cnt;
    logic cmp_meta;
    logic cmp_sync;
    logic prev_above;
    logic enabled;
    logic running;
    logic start_p;
    logic stop_p;
    logic sample_p;

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = 1'b0;
        case (a)
            OFF_START, OFF_STOP, OFF_SAMPLE, OFF_READY, OFF_DOWN, OFF_UP, OFF_CROSS,
            OFF_LINKS, OFF_IRQ_EN, OFF_IRQ_SET, OFF_IRQ_CLR, OFF_OUTCOME, OFF_ENABLE,
            OFF_PSEL, OFF_REFERENCE_SOURCE_SELECT, OFF_EXTREF, OFF_LADDER, OFF_MODE, OFF_DEADBAND: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : addr_known

    // Byte lanes outside the strobe keep their old contents; bits outside the mask stay zero.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
        logic [31:0] v;
        v = old;
        for (int b = 0; b < 4; b++) begin
            if (wr_strb[b]) begin
                v[8*b +: 8] = wr_data[8*b +: 8];
            end
        end
        return v & mask;
    endfunction : merge

    function automatic logic hit(input logic [ADDR_W-1:0] off);
        return wr_en && (wr_addr == off);
    endfunction : hit

    vcc_axil_slave u_bus (
        .clock(clock),
        .rst_n(rst_n),
        .req(axil_req),
        .rsp(axil_rsp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    assign wr_err = !addr_known(wr_addr);
    assign rd_err = !addr_known(rd_addr);

    // The core output is asynchronous to the bus clock, so it is resynchronised first.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
            prev_above <= 1'b0;
        end else begin
            cmp_meta <= core_above_async;
            cmp_sync <= cmp_meta;
            prev_above <= cmp_sync;
        end
    end

    // Tasks are single-cycle pulses from bus writes of 1 or from event links.
    always_comb begin
        start_p = hit(OFF_START) && wr_strb[0] && wr_data[0];
        stop_p = hit(OFF_STOP) && wr_strb[0] && wr_data[0];
        sample_p = hit(OFF_SAMPLE) && wr_strb[0] && wr_data[0];
        sample_p = sample_p || (links_r[LNK_READY_SAMPLE] && ev[FLG_READY]);
        stop_p = stop_p || (links_r[LNK_READY_STOP] && ev[FLG_READY]) || (links_r[LNK_DOWN_STOP] && ev[FLG_DOWN])
            || (links_r[LNK_UP_STOP] && ev[FLG_UP]) || (links_r[LNK_CROSS_STOP] && ev[FLG_CROSS]);
    end

    assign enabled = enable_r[1:0] != 2'h0;
    assign running = state == VCC_RUN;

    always_comb begin
        next_state = state;
        if (!enabled || stop_p) begin
            next_state = VCC_IDLE;
        end else begin
            unique case (state)
                VCC_IDLE: begin
                    if (start_p) begin
                        next_state = VCC_WARMUP;
                    end
                end
                VCC_WARMUP: begin
                    if (warm_cnt == WARM_LAST) begin
                        next_state = VCC_RUN;
                    end
                end
                VCC_RUN: next_state = VCC_RUN;
                default: next_state = VCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= VCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || state != VCC_WARMUP) begin
            warm_cnt <= '0;
        end else begin
            warm_cnt <= warm_cnt + WARM_W'(1);
        end
    end

    // Crossing events are only made while running, ready at the end of warm-up; the edge detector keeps tracking so no stale edge fires on entry.
    always_comb begin
        ev = '0;
        // Ready comes from the counter, not next_state, so a ready-to-stop link cannot close a loop.
        ev[FLG_READY] = (state == VCC_WARMUP) && (warm_cnt == WARM_LAST) && enabled;
        ev[FLG_UP] = running && cmp_sync && !prev_above;
        ev[FLG_DOWN] = running && !cmp_sync && prev_above;
        ev[FLG_CROSS] = ev[FLG_UP] || ev[FLG_DOWN];
    end

    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            // A new event wins over a clearing write in the same cycle.
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    flag[i] <= 1'b0;
                end else if (ev[i]) begin
                    flag[i] <= 1'b1;
                end else if (hit(FLAG_OFFS[i]) && wr_strb[0] && !wr_data[0]) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq = |(flag & irq_en_r[NUM_FLAGS-1:0]);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_en_r <= REG_RESET;
        end else if (hit(OFF_IRQ_EN)) begin
            irq_en_r <= merge(irq_en_r, MASK_IRQ);
        end else if (hit(OFF_IRQ_SET) && wr_strb[0]) begin
            irq_en_r <= irq_en_r | (wr_data & MASK_IRQ);
        end else if (hit(OFF_IRQ_CLR) && wr_strb[0]) begin
            irq_en_r <= irq_en_r & ~(wr_data & MASK_IRQ);
        end
    end

    // Configuration is not locked while enabled; software is expected to set it up before enabling.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            enable_r <= REG_RESET;
            psel_r <= REG_RESET;
            reference_source_select_r <= REG_RESET;
            extref_r <= REG_RESET;
            ladder_r <= REG_RESET;
            mode_r <= REG_RESET;
            deadband_r <= REG_RESET;
            links_r <= REG_RESET;
        end else if (wr_en) begin
            unique case (wr_addr)
                OFF_ENABLE: enable_r <= merge(enable_r, MASK_ENABLE);
                OFF_PSEL: psel_r <= merge(psel_r, MASK_SEL3);
                OFF_REFERENCE_SOURCE_SELECT: reference_source_select_r <= merge(reference_source_select_r, MASK_SEL3);
                OFF_EXTREF: extref_r <= merge(extref_r, MASK_SEL3);
                OFF_LADDER: ladder_r <= merge(ladder_r, MASK_LADDER);
                OFF_MODE: mode_r <= merge(mode_r, MASK_MODE);
                OFF_DEADBAND: deadband_r <= merge(deadband_r, MASK_DEADBAND);
                OFF_LINKS: links_r <= merge(links_r, MASK_LINKS);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            outcome <= 1'b0;
        end else if (sample_p) begin
            outcome <= cmp_sync;
        end
    end

    // Ladder tap follows the latest result, which forms the single-ended hysteresis loop.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ladder_level <= '0;
        end else if (!core_diff_mode && cmp_sync) begin
            ladder_level <= ladder_r[LADDER_LOW_LSB +: LVL_W];
        end else begin
            ladder_level <= ladder_r[LADDER_UP_LSB +: LVL_W];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            core_power <= 1'b0;
            core_speed <= SPEED_LOW;
            core_diff_mode <= 1'b0;
            core_diff_diff_deadband_enable <= 1'b0;
            pos_select <= '0;
            ref_source <= '0;
            ext_ref_pin <= '0;
            pins_claimed <= 1'b0;
        end else begin
            core_power <= next_state != VCC_IDLE;
            core_speed <= (mode_r[MODE_SPEED_LSB +: 2] == 2'h3) ? SPEED_NORMAL : mode_r[MODE_SPEED_LSB +: 2];
            core_diff_mode <= mode_r[MODE_DIFF_BIT];
            core_diff_diff_deadband_enable <= mode_r[MODE_DIFF_BIT] && deadband_r[DEADBAND_BIT];
            pos_select <= psel_r[2:0];
            ref_source <= reference_source_select_r[2:0];
            ext_ref_pin <= extref_r[2:0];
            pins_claimed <= enabled;
        end
    end

    always_comb begin
        rd_data = '0;
        unique case (rd_addr)
            OFF_READY: rd_data[0] = flag[FLG_READY];
            OFF_DOWN: rd_data[0] = flag[FLG_DOWN];
            OFF_UP: rd_data[0] = flag[FLG_UP];
            OFF_CROSS: rd_data[0] = flag[FLG_CROSS];
            OFF_LINKS: rd_data = links_r;
            OFF_IRQ_EN, OFF_IRQ_SET, OFF_IRQ_CLR: rd_data = irq_en_r;
            OFF_OUTCOME: rd_data[0] = outcome;
            OFF_ENABLE: rd_data = enable_r;
            OFF_PSEL: rd_data = psel_r;
            OFF_REFERENCE_SOURCE_SELECT: rd_data = reference_source_select_r;
            OFF_EXTREF: rd_data = extref_r;
            OFF_LADDER: rd_data = ladder_r;
            OFF_MODE: rd_data = mode_r;
            OFF_DEADBAND: rd_data = deadband_r;
            default: rd_data = '0;
        endcase
    end

    localparam int WARM_MIN = STARTUP_CYC;

    // Edges since an accepted start, counted apart from the sequencer so the ready check stays independent.
    logic [WARM_W-1:0] warm_seen;

    always_ff @(posedge clock) begin
        if (!rst_n || !enabled || stop_p) begin
            warm_seen <= '0;
        end else if (state == VCC_IDLE && start_p) begin
            warm_seen <= WARM_W'(1);
        end else if (warm_seen != '0 && warm_seen != '1) begin
            warm_seen <= warm_seen + WARM_W'(1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_start_taken;
        state == VCC_IDLE && start_p && enabled && !stop_p;
    endsequence

    sequence s_warm_undisturbed;
        enabled && !stop_p;
    endsequence

    sequence s_warm_done;
        warm_seen == WARM_W'(WARM_MIN);
    endsequence

    property p_ready_after_start;
        s_warm_done ##0 s_warm_undisturbed |=> flag[FLG_READY];
    endproperty

    start_enters_warmup_a: assert property (s_start_taken |=> state == VCC_WARMUP && core_power)
        else $error("start task did not begin warm-up");
    stop_goes_idle_a: assert property (stop_p |=> state == VCC_IDLE && !core_power)
        else $error("stop task did not power down");
    ready_delay_a: assert property (p_ready_after_start)
        else $error("ready event missing after start-up delay");
    ready_not_early_a: assert property ($rose(flag[FLG_READY]) |-> $past(warm_cnt) == WARM_LAST)
        else $error("ready event raised before start-up delay");
    rising_flag_a: assert property (running && $rose(cmp_sync) |=> flag[FLG_UP] && flag[FLG_CROSS])
        else $error("upward crossing not flagged");
    falling_flag_a: assert property (running && $fell(cmp_sync) |=> flag[FLG_DOWN] && flag[FLG_CROSS])
        else $error("downward crossing not flagged");
    cross_with_dir_a: assert property ($rose(flag[FLG_CROSS]) |-> $past(ev[FLG_UP] || ev[FLG_DOWN]))
        else $error("any-edge flag set without a crossing");
    sample_capture_a: assert property (sample_p |=> outcome == $past(cmp_sync))
        else $error("sample task did not capture comparator output");
    ladder_select_a: assert property (!mode_r[MODE_DIFF_BIT] ##1 !mode_r[MODE_DIFF_BIT] && cmp_sync
        |=> ladder_level == $past(ladder_r[LADDER_LOW_LSB +: LVL_W]))
        else $error("lower trip level not selected while above");
    deadband_masked_a: assert property (!mode_r[MODE_DIFF_BIT] |=> !core_diff_diff_deadband_enable)
        else $error("deadband active in single-ended mode");
    flag_holds_a: assert property (flag[FLG_UP] && !(hit(OFF_UP) && wr_strb[0] && !wr_data[0]) |=> flag[FLG_UP])
        else $error("rising flag dropped without a clearing write");
    irq_follows_a: assert property (flag[FLG_CROSS] && irq_en_r[FLG_CROSS] |-> irq)
        else $error("interrupt missing for enabled set flag");

endmodule : vcc_top

//--- dv/vcc_core_model.sv
// Behavioural comparator core that answers the control block with a ladder or pin reference.
`timescale 1ns/1ps
module vcc_core_model (
    // Control from the block
    input wire logic clock,
    input wire logic power,
    input wire logic diff,
    input wire logic diff_deadband_enable,
    input wire logic [5:0] level,
    // Analog levels in ladder steps
    input wire logic [5:0] pin_lvl,
    input wire logic [5:0] plus_lvl,
    // Comparator output
    output logic above
);
    int m;
    initial above = 1'b0;
    // An unpowered core has no valid output, so it toggles rather than holding a stale level.
    always @(posedge clock) begin
        m = diff ? int'(pin_lvl) : int'(level);
        if (!power) above <= ~above;
        else if (diff && diff_deadband_enable) above <= above ? (int'(plus_lvl) + 1 >= m) : (int'(plus_lvl) > m + 1);
        else above <= int'(plus_lvl) > m;
    end
endmodule : vcc_core_model

//--- dv/voltage_comparator_control_tb.sv
// Self-checking bench for the voltage comparator control block.
`timescale 1ns/1ps
module voltage_comparator_control_tb import vcc_pkg::*;;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    vcc_axil_req_s req = '0;
    vcc_axil_rsp_s rsp;
    logic above, core_power, core_diff_mode, core_diff_diff_deadband_enable, pins_claimed, irq;
    logic [1:0] core_speed, resp;
    logic [2:0] pos_select, ref_source, ext_ref_pin;
    logic [5:0] ladder_level, plus_lvl = 6'h00, pin_lvl = 6'h00;
    logic [31:0] rdat;
    logic exp_above = 1'b0;
    logic [2:0] refs [5] = '{REF_INT_1V2, REF_INT_1V8, REF_INT_2V4, REF_PIN, REF_SUPPLY};
    int num_errors = 0, total_checks = 0, p;
    vcc_top dut_u (.clock(clock), .rst_n(rst_n), .axil_req(req), .axil_rsp(rsp), .core_above_async(above),
        .core_power(core_power), .core_speed(core_speed), .core_diff_mode(core_diff_mode),
        .core_diff_diff_deadband_enable(core_diff_diff_deadband_enable), .pos_select(pos_select), .ref_source(ref_source),
        .ext_ref_pin(ext_ref_pin), .ladder_level(ladder_level), .pins_claimed(pins_claimed), .irq(irq));
    vcc_core_model core_u (.clock(clock), .power(core_power), .diff(core_diff_mode), .diff_deadband_enable(core_diff_diff_deadband_enable),
        .level(ladder_level), .pin_lvl(pin_lvl), .plus_lvl(plus_lvl), .above(above));
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // Readies are sampled at the falling edge, where they already equal what the next rising edge sees.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, b;
        @(posedge clock);
        req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d, wstrb:4'hf, bready:1'b1, default:'0};
        b = 1'b0;
        while (!b) begin
            @(negedge clock);
            ta = rsp.awready;
            tw = rsp.wready;
            b = rsp.bvalid;
            resp = rsp.bresp;
            @(posedge clock);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
        end
        req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic ta, b;
        @(posedge clock);
        req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
        b = 1'b0;
        while (!b) begin
            @(negedge clock);
            ta = rsp.arready;
            b = rsp.rvalid;
            rdat = rsp.rdata;
            resp = rsp.rresp;
            @(posedge clock);
            if (ta) req.arvalid <= 1'b0;
        end
        req.rready <= 1'b0;
    endtask : rd
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(n, rdat, e);
    endtask : rchk
    task automatic settle;
        repeat (3) @(negedge clock);
    endtask : settle
    // Leaves room for the two-flop synchroniser and the flag edge before sampling.
    task automatic samp(input logic e);
        repeat (6) @(posedge clock);
        wr(OFF_SAMPLE, 32'h1);
        rchk("outcome", OFF_OUTCOME, {31'h0, e});
    endtask : samp
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hbe79));
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rchk("mode", OFF_MODE, REG_RESET);
        rchk("enable", OFF_ENABLE, REG_RESET);
        rd(12'h600);
        chk("bad_resp", 32'(resp), 32'(RESP_SLVERR));
        chk("bad_data", rdat, 32'h0);
        wr(OFF_PSEL, 32'(PSEL_HALF_SUPPLY));
        wr(OFF_EXTREF, 32'h3);
        wr(OFF_LADDER, 32'h2814);
        wr(OFF_DEADBAND, 32'h1);
        foreach (refs[i]) begin
            wr(OFF_REFERENCE_SOURCE_SELECT, 32'(refs[i]));
            settle();
            chk("ref", 32'(ref_source), 32'(refs[i]));
        end
        for (int s = 0; s < 4; s++) begin
            wr(OFF_MODE, 32'(s));
            settle();
            chk("speed", 32'(core_speed), 32'((s == 3) ? SPEED_NORMAL : 2'(s)));
        end
        chk("psel", 32'(pos_select), 32'(PSEL_HALF_SUPPLY));
        chk("extref", 32'(ext_ref_pin), 32'h3);
        chk("se_diff_deadband_enable", 32'(core_diff_diff_deadband_enable), 32'h0);
        wr(OFF_ENABLE, 32'h1);
        wr(OFF_IRQ_SET, 32'h4);
        settle();
        chk("claimed", 32'(pins_claimed), 32'h1);
        wr(OFF_START, 32'h1);
        rchk("early_ready", OFF_READY, 32'h0);
        repeat (STARTUP_CYC) @(posedge clock);
        rchk("ready", OFF_READY, 32'h1);
        chk("power", 32'(core_power), 32'h1);
        plus_lvl <= 6'h32;
        samp(1'b1);
        rchk("up", OFF_UP, 32'h1);
        rchk("cross", OFF_CROSS, 32'h1);
        rchk("down", OFF_DOWN, 32'h0);
        chk("lower_tap", 32'(ladder_level), 32'h14);
        chk("irq_on", 32'(irq), 32'h1);
        wr(OFF_UP, 32'h0);
        wr(OFF_CROSS, 32'h0);
        rchk("up_clr", OFF_UP, 32'h0);
        chk("irq_off", 32'(irq), 32'h0);
        plus_lvl <= 6'h1e;
        samp(1'b1);
        plus_lvl <= 6'h0a;
        samp(1'b0);
        rchk("down_set", OFF_DOWN, 32'h1);
        chk("upper_tap", 32'(ladder_level), 32'h28);
        repeat (8) begin
            p = $urandom_range(63, 0);
            plus_lvl <= 6'(p);
            exp_above = exp_above ? (p > 20) : (p > 40);
            samp(exp_above);
        end
        wr(OFF_STOP, 32'h1);
        settle();
        chk("stopped", 32'(core_power), 32'h0);
        // Differential set-up is only legal while disabled, which also shows a disabled start is ignored.
        wr(OFF_ENABLE, 32'h0);
        wr(OFF_START, 32'h1);
        settle();
        chk("no_start", 32'(core_power), 32'h0);
        chk("released", 32'(pins_claimed), 32'h0);
        wr(OFF_MODE, 32'h101);
        pin_lvl <= 6'h1e;
        plus_lvl <= 6'h0a;
        wr(OFF_ENABLE, 32'h1);
        wr(OFF_START, 32'h1);
        repeat (STARTUP_CYC) @(posedge clock);
        chk("diff", 32'(core_diff_mode), 32'h1);
        chk("diff_diff_deadband_enable", 32'(core_diff_diff_deadband_enable), 32'h1);
        chk("diff_power", 32'(core_power), 32'h1);
        samp(1'b0);
        plus_lvl <= 6'h1f;
        samp(1'b0);
        plus_lvl <= 6'h20;
        samp(1'b1);
        plus_lvl <= 6'h1d;
        samp(1'b1);
        wr(OFF_LINKS, 32'(1 << LNK_UP_STOP));
        plus_lvl <= 6'h0a;
        samp(1'b0);
        plus_lvl <= 6'h20;
        repeat (6) @(posedge clock);
        chk("link_stop", 32'(core_power), 32'h0);
        rchk("task_read", OFF_SAMPLE, 32'h0);
        give_verdict();
    end
endmodule : voltage_comparator_control_tb
